// ---- pkg/ssa_pkg.sv ----
// constants and types for the serial synthesizer control block
package ssa_pkg;

	// ----------------------------------------------------------------
	// ----------------------------------------------------------------

	localparam int         WORD_W       = 26;
	localparam int         CODE_W       = 7;
	localparam logic [1:0] ADDR_OPMODE  = 2'h0;
	localparam logic [1:0] ADDR_AUTOCAL = 2'h1;
	localparam logic [1:0] ADDR_FREQ1   = 2'h2;
	localparam logic [1:0] ADDR_FREQ2   = 2'h3;

	// operation-mode field positions, plus the tune-enable bit of the autocal word
	localparam int PUMP_CUR_LSB = 2;
	localparam int HIGHZ_BIT    = 8;
	localparam int MOD_SUP_BIT  = 10;
	localparam int DIV_SUP_BIT  = 11;
	localparam int PLL_SUP_BIT  = 12;
	localparam int REFBW_LSB    = 13;
	localparam int DIAG_LSB     = 15;
	localparam int BIAS_LSB     = 21;
	localparam int PRESC_BIT    = 23;
	localparam int TUNE_EN_BIT  = 20;

	localparam logic [10:0] PUMP_BASE_UA  = 11'h0C8;
	localparam logic [10:0] PUMP_STEP_UA  = 11'h0C8;
	localparam logic [10:0] REFBW_BASE    = 11'h014;
	localparam logic [10:0] REFBW_STEP    = 11'h00A;
	localparam logic [10:0] BIAS_BASE_UA  = 11'h014;
	localparam logic [10:0] BIAS_STEP_UA  = 11'h002;

	localparam logic [2:0] DIAG_LOCK   = 3'h0;
	localparam logic [2:0] DIAG_REFDIV = 3'h1;
	localparam logic [2:0] DIAG_FBDIV  = 3'h2;
	localparam logic [2:0] DIAG_TUNE   = 3'h7;

	localparam logic [1:0]        PUMP_DELAY_FIXED = 2'h0;
	localparam logic              POLARITY_NEG     = 1'b0;
	localparam logic [WORD_W-1:0] HOLD_RESET       = 26'h0000000;
	localparam logic [CODE_W-1:0] CODE_MID         = 7'h40;

	// coarse search settle time per step
	localparam int CLK_PERIOD_NS = 4;
	localparam int TUNE_STEP_NS  = 400;
	localparam int TUNE_STEP_CYC = (TUNE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic {TUNE_IDLE, TUNE_SEARCH} ssa_tune_t;

endpackage

// ---- rtl/ssa_autotune.sv ----
// coarse oscillator capacitor search by successive approximation
`timescale 1ns/1ps
module ssa_autotune
	import ssa_pkg::*;
#(
	parameter int STEP_CYC = TUNE_STEP_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              freqChange,
	input  wire logic              tuneEnRise,
	input  wire logic              oscFast,
	output logic      [CODE_W-1:0] coarseCode,
	output logic                   fineTuneEn,
	output logic                   tuneBusy
);

	ssa_tune_t         state_ff, nxt_state;
	logic [CODE_W-1:0] code_ff, nxt_code;
	logic [2:0]        bitIdx_ff, nxt_bitIdx;
	logic [15:0]       cnt_ff, nxt_cnt;
	logic              pend_ff, nxt_pend;
	logic              fine_ff, nxt_fine;

	// ----------------------------------------------------------------
	// search engine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state  = state_ff;
		nxt_code   = code_ff;
		nxt_bitIdx = bitIdx_ff;
		nxt_cnt    = cnt_ff;
		nxt_pend   = pend_ff;
		nxt_fine   = fine_ff;
		case (state_ff)
			TUNE_IDLE: begin
				if (tuneEnRise && pend_ff) begin
					nxt_state  = TUNE_SEARCH;
					nxt_code   = CODE_MID;
					nxt_bitIdx = 3'(CODE_W - 1);
					nxt_cnt    = 16'h0000;
					nxt_pend   = 1'b0;
					nxt_fine   = 1'b0;
				end
			end
			default: begin
				if (cnt_ff == 16'(STEP_CYC - 1)) begin
					nxt_cnt = 16'h0000;
					if (oscFast) begin
						nxt_code[bitIdx_ff] = 1'b0;
					end
					if (bitIdx_ff == 3'h0) begin
						nxt_state = TUNE_IDLE;
						nxt_fine  = 1'b1;
					end else begin
						nxt_bitIdx           = bitIdx_ff - 3'h1;
						nxt_code[nxt_bitIdx] = 1'b1;
					end
				end else begin
					nxt_cnt = cnt_ff + 16'h0001;
				end
			end
		endcase
		// a change landing on the start cycle re-arms, set beats clear
		if (freqChange) begin
			nxt_pend = 1'b1;
		end
	end

	// pending starts at one: reset itself arms the first run
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff  <= TUNE_IDLE;
			code_ff   <= CODE_MID;
			bitIdx_ff <= 3'h0;
			cnt_ff    <= 16'h0000;
			pend_ff   <= 1'b1;
			fine_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			code_ff   <= nxt_code;
			bitIdx_ff <= nxt_bitIdx;
			cnt_ff    <= nxt_cnt;
			pend_ff   <= nxt_pend;
			fine_ff   <= nxt_fine;
		end
	end

	assign coarseCode = code_ff;
	assign fineTuneEn = fine_ff;
	assign tuneBusy   = (state_ff == TUNE_SEARCH);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_fine_after_search: assert property (tuneBusy |-> !fineTuneEn)
		else $error("fine tuning on during coarse search");
	a_fine_at_end: assert property ($fell(tuneBusy) |-> fineTuneEn)
		else $error("fine tuning not enabled after search");
	a_start_armed: assert property ($rose(tuneBusy) |-> $past(pend_ff) && $past(tuneEnRise))
		else $error("search started without arming");
	a_search_start: assert property ($rose(tuneBusy) |->
		coarseCode == CODE_MID && bitIdx_ff == 3'h6)
		else $error("search did not start at mid code");
	a_search_end: assert property ($fell(tuneBusy) |-> $past(bitIdx_ff) == 3'h0)
		else $error("search ended before seventh step");

	c_search_run: cover property ($rose(tuneBusy));
	c_search_done: cover property ($rose(fineTuneEn));

endmodule // ssa_autotune

// ---- rtl/ssa_top.sv ----
// three-wire serial port, hold registers and operation-mode decode
`timescale 1ns/1ps
module ssa_top
	import ssa_pkg::*;
#(
	parameter int STEP_CYC = TUNE_STEP_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              serClk,
	input  wire logic              serData,
	input  wire logic              load_strobe,
	input  wire logic              lockDetect,
	input  wire logic              refDivOut,
	input  wire logic              fbDivOut,
	input  wire logic              oscFast,
	output logic      [10:0]       pumpCurrentUa,
	output logic      [1:0]        pumpDelayCode,
	output logic                   detectorPolarity,
	output logic                   pumpHighZ,
	output logic                   modulatorSupplySel,
	output logic                   dividerSupplySel,
	output logic                   pllSupplySel,
	output logic      [10:0]       refbufBandwidthMhz,
	output logic      [10:0]       prescBiasUa,
	output logic                   prescDiv16,
	output logic                   lockIndicatorPin,
	output logic      [WORD_W-1:0] autocalWord,
	output logic      [WORD_W-1:0] freqWordOne,
	output logic      [WORD_W-1:0] freqWordTwo,
	output logic      [CODE_W-1:0] coarseCode,
	output logic                   fineTuneEn,
	output logic                   tuneBusy
);

	function automatic logic [10:0] ssaScale(input logic [1:0] code, input logic [10:0] base,
		input logic [10:0] step);
		return 11'(base + 11'({9'h000, code} * step));
	endfunction

	// ----------------------------------------------------------------
	// serial port and hold registers
	// ----------------------------------------------------------------
	logic [2:0]        sync1_ff, nxt_sync1;
	logic [2:0]        sync2_ff, nxt_sync2;
	logic [2:0]        prev_ff, nxt_prev;
	logic [WORD_W-1:0] shift_ff, nxt_shift;
	logic [WORD_W-1:0] hold_ff [4];
	logic [WORD_W-1:0] nxt_hold [4];
	logic              freqChg_ff, nxt_freqChg;
	logic              tuneRise_ff, nxt_tuneRise;
	logic              clkRise;
	logic              strobeFall;
	logic              dataS;
	logic              strobeS;

	// bit 0 clock, bit 1 data, bit 2 strobe; stage two and its delayed copy in prev_ff are looked at
	assign clkRise    = sync2_ff[0] && !prev_ff[0];
	assign strobeFall = !sync2_ff[2] && prev_ff[2];
	assign dataS      = sync2_ff[1];
	assign strobeS    = sync2_ff[2];

	always_comb begin
		nxt_sync1    = {load_strobe, serData, serClk};
		nxt_sync2    = sync1_ff;
		nxt_prev     = sync2_ff;
		nxt_shift    = shift_ff;
		nxt_hold     = hold_ff;
		nxt_freqChg  = 1'b0;
		nxt_tuneRise = 1'b0;
		if (clkRise && !strobeS) begin
			nxt_shift = {shift_ff[WORD_W-2:0], dataS};
		end
		if (strobeFall) begin
			nxt_hold[shift_ff[1:0]] = shift_ff;
			// only the frequency words may arm a new search
			if (shift_ff[1:0] == ADDR_FREQ1 || shift_ff[1:0] == ADDR_FREQ2) begin
				nxt_freqChg = (hold_ff[shift_ff[1:0]] != shift_ff);
			end
			if (shift_ff[1:0] == ADDR_AUTOCAL) begin
				nxt_tuneRise = !hold_ff[ADDR_AUTOCAL][TUNE_EN_BIT] && shift_ff[TUNE_EN_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sync1_ff    <= 3'h4;
			sync2_ff    <= 3'h4;
			prev_ff     <= 3'h4;
			shift_ff    <= HOLD_RESET;
			hold_ff     <= '{default: HOLD_RESET};
			freqChg_ff  <= 1'b0;
			tuneRise_ff <= 1'b0;
		end else begin
			sync1_ff    <= nxt_sync1;
			sync2_ff    <= nxt_sync2;
			prev_ff     <= nxt_prev;
			shift_ff    <= nxt_shift;
			hold_ff     <= nxt_hold;
			freqChg_ff  <= nxt_freqChg;
			tuneRise_ff <= nxt_tuneRise;
		end
	end

	// ----------------------------------------------------------------
	// operation-mode decode and diagnostic routing
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] opWord;
	logic [10:0]       pumpCur_ff, nxt_pumpCur;
	logic              highZ_ff, nxt_highZ;
	logic [2:0]        supply_ff, nxt_supply;
	logic [10:0]       refbw_ff, nxt_refbw;
	logic [10:0]       bias_ff, nxt_bias;
	logic              presc_ff, nxt_presc;
	logic              diag_ff, nxt_diag;
	logic [2:0]        diagSel;
	logic              tuneTest;

	assign opWord  = hold_ff[ADDR_OPMODE];
	assign diagSel = opWord[DIAG_LSB +: 3];

	always_comb begin
		nxt_pumpCur = 11'(PUMP_BASE_UA + 11'({8'h00, opWord[PUMP_CUR_LSB +: 3]} * PUMP_STEP_UA));
		nxt_highZ   = opWord[HIGHZ_BIT];
		nxt_supply  = {opWord[PLL_SUP_BIT], opWord[DIV_SUP_BIT], opWord[MOD_SUP_BIT]};
		nxt_refbw   = ssaScale(opWord[REFBW_LSB +: 2], REFBW_BASE, REFBW_STEP);
		nxt_bias    = ssaScale(opWord[BIAS_LSB +: 2], BIAS_BASE_UA, BIAS_STEP_UA);
		nxt_presc   = opWord[PRESC_BIT];
		// unused selects park the pin low rather than float a stale source
		if (diagSel == DIAG_LOCK) begin
			nxt_diag = lockDetect;
		end else if (diagSel == DIAG_REFDIV) begin
			nxt_diag = refDivOut;
		end else if (diagSel == DIAG_FBDIV) begin
			nxt_diag = fbDivOut;
		end else if (diagSel == DIAG_TUNE) begin
			nxt_diag = tuneTest;
		end else begin
			nxt_diag = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pumpCur_ff <= PUMP_BASE_UA;
			highZ_ff   <= 1'b0;
			supply_ff  <= 3'h0;
			refbw_ff   <= REFBW_BASE;
			bias_ff    <= BIAS_BASE_UA;
			presc_ff   <= 1'b0;
			diag_ff    <= 1'b0;
		end else begin
			pumpCur_ff <= nxt_pumpCur;
			highZ_ff   <= nxt_highZ;
			supply_ff  <= nxt_supply;
			refbw_ff   <= nxt_refbw;
			bias_ff    <= nxt_bias;
			presc_ff   <= nxt_presc;
			diag_ff    <= nxt_diag;
		end
	end

	// written delay and polarity fields are ignored: the part is fixed
	assign pumpDelayCode      = PUMP_DELAY_FIXED;
	assign detectorPolarity   = POLARITY_NEG;
	assign pumpCurrentUa      = pumpCur_ff;
	assign pumpHighZ          = highZ_ff;
	assign modulatorSupplySel = supply_ff[0];
	assign dividerSupplySel   = supply_ff[1];
	assign pllSupplySel       = supply_ff[2];
	assign refbufBandwidthMhz = refbw_ff;
	assign prescBiasUa        = bias_ff;
	assign prescDiv16         = presc_ff;
	assign lockIndicatorPin   = diag_ff;
	assign autocalWord        = hold_ff[ADDR_AUTOCAL];
	assign freqWordOne        = hold_ff[ADDR_FREQ1];
	assign freqWordTwo        = hold_ff[ADDR_FREQ2];
	assign tuneTest           = tuneBusy;

	// ----------------------------------------------------------------
	// coarse tuning engine
	// ----------------------------------------------------------------
	ssa_autotune #(
		.STEP_CYC (STEP_CYC)
	) u_tune (
		.sys_clk    (sys_clk),
		.resetn     (resetn),
		.freqChange (freqChg_ff),
		.tuneEnRise (tuneRise_ff),
		.oscFast    (oscFast),
		.coarseCode (coarseCode),
		.fineTuneEn (fineTuneEn),
		.tuneBusy   (tuneBusy)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_shift_gated: assert property (strobeS |=> $stable(shift_ff))
		else $error("load register moved while strobe high");
	a_shift_msb: assert property (clkRise && !strobeS |=> shift_ff[0] == $past(dataS))
		else $error("serial bit not shifted in at bottom");
	a_latch_dest: assert property (strobeFall |=>
		hold_ff[$past(shift_ff[1:0])] == $past(shift_ff))
		else $error("hold register not loaded on strobe fall");
	// decoded outputs trail the hold word by one register stage
	a_pump_current: assert property (##1 pumpCurrentUa ==
		11'(({8'h00, $past(opWord[4:2])} + 11'h001) * 11'h0C8))
		else $error("pump current wrong");
	a_fixed_fields: assert property (pumpDelayCode == 2'h0 && !detectorPolarity)
		else $error("fixed pump delay or polarity changed");
	a_high_z: assert property (##1 pumpHighZ == $past(opWord[8]))
		else $error("pump high impedance bit not followed");
	a_refbuf_bw: assert property (##1 refbufBandwidthMhz ==
		11'(11'h014 + 11'({9'h000, $past(opWord[14:13])} * 11'h00A)))
		else $error("reference bandwidth wrong");
	a_diag_lock: assert property ($past(diagSel) == 3'h0 |-> lockIndicatorPin == $past(lockDetect))
		else $error("lock indicator not routed");
	a_diag_tune: assert property ($past(diagSel) == 3'h7 |-> lockIndicatorPin == $past(tuneBusy))
		else $error("tune test not routed");
	a_presc_bias: assert property (##1 prescBiasUa ==
		11'(11'h014 + 11'({9'h000, $past(opWord[22:21])} * 11'h002)))
		else $error("prescaler bias wrong");
	a_presc_mode: assert property (##1 prescDiv16 == $past(opWord[23]))
		else $error("prescaler mode not followed");
	a_quiet_write: assert property (strobeFall && !shift_ff[1] |=> !freqChg_ff)
		else $error("non-frequency write armed tuning");

	c_op_write: cover property (strobeFall && shift_ff[1:0] == ADDR_OPMODE);
	c_freq_change: cover property (freqChg_ff);
	c_enable_rise: cover property (tuneRise_ff);

endmodule // ssa_top

// ---- sim/ssa_host_model.sv ----
// host-side model driving the three-wire serial port
`timescale 1ns/1ps
module ssa_host_model (
	output logic serClk,
	output logic serData,
	output logic load_strobe
);
	// ------------------------------------------------
	// word transfer
	// ------------------------------------------------
	// clock stands low between frames; data shows inverse once hold ends
	initial begin
		serClk      = 1'b0;
		serData     = 1'b0;
		load_strobe = 1'b1;
	end

	task automatic send_word(input logic [25:0] w);
		load_strobe = 1'b0;
		#20;
		for (int i = 25; i >= 0; i--) begin
			serData = w[i];
			#31 serClk = 1'b1;
			#31 serData = ~w[i];
			#31 serClk = 1'b0;
			#32;
		end
		load_strobe = 1'b1;
		#20 load_strobe = 1'b0;
		#40;
	endtask
endmodule // ssa_host_model

// ---- sim/synth_serial_ctrl_autotune_tb.sv ----
// self-checking bench for the serial synthesizer control block
`timescale 1ns/1ps
module synth_serial_ctrl_autotune_tb;
	import ssa_pkg::*;
	localparam int STEP = 4;
	logic              sys_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              lockDetect = 1'b0;
	logic              refDivOut = 1'b0;
	logic              fbDivOut = 1'b0;
	logic              oscFast = 1'b0;
	logic [10:0]       pumpCur, refBw, biasUa;
	logic [1:0]        delayCode;
	logic              polar, highZ, modSup, divSup, pllSup, div16, lockPin;
	logic [WORD_W-1:0] autocalWord, freqWordOne, freqWordTwo;
	logic [CODE_W-1:0] coarseCode;
	logic              fineTuneEn, tuneBusy, serClk, serData, load_strobe;
	logic [25:0]       hold [4];
	logic [6:0]        tgt = 7'h00;
	logic [6:0]        expCode;
	logic              pend, expFine;
	int                seed = 74293;
	int                n_fail = 0;
	int                n_compared = 0;

	always #2 sys_clk = ~sys_clk;
	// oscillator stand-in: fast while code is above target
	always @(negedge sys_clk) oscFast <= (coarseCode > tgt);

	ssa_host_model ssa_host_model_inst (.serClk(serClk), .serData(serData),
		.load_strobe(load_strobe));

	ssa_top #(.STEP_CYC(STEP)) ssa_top_inst (.sys_clk(sys_clk), .resetn(resetn),
		.serClk(serClk), .serData(serData), .load_strobe(load_strobe),
		.lockDetect(lockDetect), .refDivOut(refDivOut), .fbDivOut(fbDivOut),
		.oscFast(oscFast), .pumpCurrentUa(pumpCur), .pumpDelayCode(delayCode),
		.detectorPolarity(polar), .pumpHighZ(highZ), .modulatorSupplySel(modSup),
		.dividerSupplySel(divSup), .pllSupplySel(pllSup), .refbufBandwidthMhz(refBw),
		.prescBiasUa(biasUa), .prescDiv16(div16), .lockIndicatorPin(lockPin),
		.autocalWord(autocalWord), .freqWordOne(freqWordOne),
		.freqWordTwo(freqWordTwo), .coarseCode(coarseCode),
		.fineTuneEn(fineTuneEn), .tuneBusy(tuneBusy));

	// ------------------------------------------------
	// checking helpers
	// ------------------------------------------------
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_all();
		logic [25:0] op;
		op = hold[0];
		chk("pump", 26'((int'(op[4:2]) + 1) * 32'hC8), pumpCur);
		chk("delay", 26'h0, delayCode);
		chk("polar", 26'h0, polar);
		chk("highz", op[8], highZ);
		chk("supply", op[12:10], {pllSup, divSup, modSup});
		chk("refbw", 26'(32'h14 + 32'hA * int'(op[14:13])), refBw);
		chk("bias", 26'(32'h14 + 32'h2 * int'(op[22:21])), biasUa);
		chk("presc", op[23], div16);
		chk("autocal", hold[1], autocalWord);
		chk("freq1", hold[2], freqWordOne);
		chk("freq2", hold[3], freqWordTwo);
		chk("code", expCode, coarseCode);
		chk("fine", expFine, fineTuneEn);
	endtask

	task automatic chk_diag();
		logic e;
		repeat (4) begin
			@(negedge sys_clk);
			{lockDetect, refDivOut, fbDivOut} = 3'($random(seed));
			repeat (3) @(negedge sys_clk);
			case (hold[0][17:15])
				3'h0: e = lockDetect;
				3'h1: e = refDivOut;
				3'h2: e = fbDivOut;
				default: e = 1'b0;
			endcase
			chk("diag", e, lockPin);
		end
	endtask

	// writes one word, updates the expected state, then compares
	task automatic wr(input logic [25:0] w);
		logic run;
		run = pend && w[1:0] == 2'h1 && !hold[1][20] && w[20];
		if (w[1] && hold[w[1:0]] !== w)
			pend = 1'b1;
		if (run)
			pend = 1'b0;
		hold[w[1:0]] = w;
		ssa_host_model_inst.send_word(w);
		@(negedge sys_clk);
		if (run) begin
			chk("busy", 26'h1, tuneBusy);
			chk("fine", 26'h0, fineTuneEn);
			// select 7 shows the running search on the diagnostic pin
			chk("diag", {25'h0, hold[0][17:15] == 3'h7}, lockPin);
			for (int i = 0; i < 200 && tuneBusy === 1'b1; i++)
				@(negedge sys_clk);
			expCode = tgt;
			expFine = 1'b1;
		end
		chk("busy", 26'h0, tuneBusy);
		chk_all();
	endtask

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		hold = '{default: 26'h0};
		pend = 1'b1;
		expCode = 7'h40;
		expFine = 1'b0;
		repeat (16) @(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		chk_all();
		// reserved zero, delay 00, polarity 0, supplies 100
		for (int i = 0; i < 8; i++) begin
			wr({2'h0, i[0], 2'($random(seed)), 3'h0, i[2:0], 2'(i), 3'h4, 1'h0, i[1],
				3'h0, i[2:0], 2'h0});
			chk_diag();
		end
		wr({5'h0, 1'h0, 18'($random(seed)), 2'h1});
		wr({24'($random(seed)), 2'h2});
		wr({24'($random(seed)), 2'h3});
		tgt = 7'($random(seed));
		wr(hold[1] | 26'h100000);
		wr(hold[1] & ~26'h100000);
		wr(hold[1] | 26'h100000);
		wr(hold[2]);
		// boundary targets first, then a random one
		for (int k = 0; k < 3; k++) begin
			tgt = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : 7'($random(seed));
			wr(hold[1] & ~26'h100000);
			wr(hold[3] ^ 26'h4);
			wr(hold[1] | 26'h100000);
		end
		complete_run();
	end

	// hang guard, well beyond the expected run length
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end
endmodule // synth_serial_ctrl_autotune_tb
